// File: inc/rtcv_pkg.sv
// Shared constants and types of the real time counter value block
package rtcv_pkg;

  // Register byte offsets
  localparam logic [7:0] RTCV_OFS_CTRL = 8'h00;
  localparam logic [7:0] RTCV_OFS_FLAGS = 8'h08;
  localparam logic [7:0] RTCV_OFS_STATUS = 8'h0c;
  localparam logic [7:0] RTCV_OFS_VALUE = 8'h10;
  localparam logic [7:0] RTCV_OFS_TOP = 8'h14;
  localparam logic [7:0] RTCV_OFS_MATCH = 8'h18;

  // Control register layout
  localparam int RTCV_CTRL_W = 9;
  localparam int RTCV_CTRL_EN_BIT = 0;
  localparam int RTCV_CTRL_MODE_LSB = 2;
  localparam int RTCV_CTRL_TWELVE_BIT = 6;
  localparam int RTCV_CTRL_CLR_BIT = 7;
  localparam int RTCV_CTRL_WPROT_BIT = 8;

  // Flag and status layout
  localparam int RTCV_FLAG_MATCH_BIT = 0;
  localparam int RTCV_FLAG_WRAP_BIT = 7;
  localparam int RTCV_STAT_SYNC_BIT = 7;

  // Calendar word fields
  localparam int RTCV_YEAR_LSB = 26;
  localparam int RTCV_MONTH_LSB = 22;
  localparam int RTCV_DAY_LSB = 17;
  localparam int RTCV_HOUR_LSB = 12;
  localparam int RTCV_MIN_LSB = 6;
  localparam int RTCV_SEC_LSB = 0;

  // Calendar limits
  localparam logic [5:0] RTCV_SEC_MAX = 6'h3b;
  localparam logic [5:0] RTCV_MIN_MAX = 6'h3b;
  localparam logic [4:0] RTCV_HOUR24_MAX = 5'h17;
  localparam logic [3:0] RTCV_HOUR12_MAX = 4'hc;
  localparam logic [3:0] RTCV_HOUR12_PRE = 4'hb;
  localparam logic [3:0] RTCV_MONTH_MAX = 4'hc;
  localparam logic [3:0] RTCV_FEB = 4'h2;
  localparam logic [3:0] RTCV_APR = 4'h4;
  localparam logic [3:0] RTCV_JUN = 4'h6;
  localparam logic [3:0] RTCV_SEP = 4'h9;
  localparam logic [3:0] RTCV_NOV = 4'hb;
  localparam logic [4:0] RTCV_DAYS_28 = 5'h1c;
  localparam logic [4:0] RTCV_DAYS_29 = 5'h1d;
  localparam logic [4:0] RTCV_DAYS_30 = 5'h1e;
  localparam logic [4:0] RTCV_DAYS_31 = 5'h1f;

  // Reset values
  localparam logic [31:0] RTCV_VALUE_RST = 32'h0000_0000;
  localparam logic [15:0] RTCV_TOP_RST = 16'h0000;
  localparam logic [31:0] RTCV_MATCH_RST = 32'h0000_0000;
  localparam logic [8:0] RTCV_CTRL_RST = 9'h000;

  // Bus clocks spent capturing a value read
  localparam logic [1:0] RTCV_RD_SYNC_CYC = 2'h2;

  // Counting modes, encoded as the control mode field
  typedef enum logic [1:0] {
    RTCV_MODE_C32,
    RTCV_MODE_C16,
    RTCV_MODE_CAL,
    RTCV_MODE_RSVD
  } rtcv_mode_t;

  // Cross-domain synchronisation states
  typedef enum logic [1:0] {
    RTCV_SYNC_IDLE,
    RTCV_SYNC_WR,
    RTCV_SYNC_RD
  } rtcv_sync_t;

endpackage : rtcv_pkg

// File: src/rtcv_pin_sync.sv
// Three-stage synchroniser with agreement filter for the tick pin
module rtcv_pin_sync
  import rtcv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic [2:0] ff;
    logic lvl;
  } rtcv_psync_t;

  rtcv_psync_t s_r;
  rtcv_psync_t s_nxt;

  // Shift chain; level follows only when stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.ff = {s_r.ff[1:0], pin};
    if (s_r.ff[1] == s_r.ff[2]) begin
      s_nxt.lvl = s_r.ff[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;

endmodule : rtcv_pin_sync

// File: src/rtcv_cal_next.sv
// Next calendar word after one second, with year wrap detection
module rtcv_cal_next
  import rtcv_pkg::*;
(
  input wire logic [31:0] cal,
  input wire logic twelve_hour_select,
  output logic [31:0] cal_nxt,
  output logic year_wrap
);

  logic [5:0] year;
  logic [3:0] month;
  logic [4:0] day;
  logic [4:0] hour;
  logic [5:0] minute;
  logic [5:0] second;
  logic [4:0] last_day;
  logic c_min;
  logic c_hour;
  logic c_day;
  logic c_month;
  logic c_year;

  // Month length from month and leap year
  always_comb begin
    last_day = RTCV_DAYS_31;
    if (cal[RTCV_MONTH_LSB +: 4] == RTCV_FEB) begin
      last_day = (cal[RTCV_YEAR_LSB +: 2] == 2'h0) ?
                 RTCV_DAYS_29 : RTCV_DAYS_28;
    end else if (cal[RTCV_MONTH_LSB +: 4] == RTCV_APR ||
                 cal[RTCV_MONTH_LSB +: 4] == RTCV_JUN ||
                 cal[RTCV_MONTH_LSB +: 4] == RTCV_SEP ||
                 cal[RTCV_MONTH_LSB +: 4] == RTCV_NOV) begin
      last_day = RTCV_DAYS_30;
    end
  end

  // Ripple the carry through the fields
  always_comb begin
    year = cal[RTCV_YEAR_LSB +: 6];
    month = cal[RTCV_MONTH_LSB +: 4];
    day = cal[RTCV_DAY_LSB +: 5];
    hour = cal[RTCV_HOUR_LSB +: 5];
    minute = cal[RTCV_MIN_LSB +: 6];
    second = cal[RTCV_SEC_LSB +: 6];
    c_min = (second >= RTCV_SEC_MAX);
    second = c_min ? 6'h00 : second + 6'h01;
    c_hour = c_min && (minute >= RTCV_MIN_MAX);
    if (c_min) begin
      minute = c_hour ? 6'h00 : minute + 6'h01;
    end
    c_day = 1'b0;
    if (c_hour && !twelve_hour_select) begin
      c_day = (hour >= RTCV_HOUR24_MAX);
      hour = c_day ? 5'h00 : hour + 5'h01;
    end else if (c_hour) begin
      if (hour[3:0] == RTCV_HOUR12_PRE) begin
        c_day = hour[4];
        hour = {~hour[4], RTCV_HOUR12_MAX};
      end else if (hour[3:0] >= RTCV_HOUR12_MAX) begin
        hour = {hour[4], 4'h1};
      end else begin
        hour = {hour[4], hour[3:0] + 4'h1};
      end
    end
    c_month = c_day && (day >= last_day);
    if (c_day) begin
      day = c_month ? 5'h01 : day + 5'h01;
    end
    c_year = c_month && (month >= RTCV_MONTH_MAX);
    if (c_month) begin
      month = c_year ? 4'h1 : month + 4'h1;
    end
    year_wrap = c_year && (year == 6'h3f);
    if (c_year) begin
      year = year + 6'h01;
    end
    cal_nxt = {year, month, day, hour, minute, second};
  end

endmodule : rtcv_cal_next

// File: src/rtcv_top.sv
// Real time counter value datapath with APB register access
module rtcv_top
  import rtcv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tick_clock,
  output logic sync_pending,
  output logic match_flag,
  output logic wrap_flag
);

  typedef struct packed {
    logic [RTCV_CTRL_W-1:0] ctrl;
    logic [31:0] count;
    logic [15:0] top;
    logic [31:0] match;
    logic wrap;
    logic mflag;
    rtcv_sync_t st;
    logic [1:0] cnt;
    logic [31:0] wdata;
    logic [7:0] waddr;
    logic tprev;
    logic [31:0] prdata;
  } rtcv_state_t;

  rtcv_state_t s_r;
  rtcv_state_t s_nxt;

  logic tick_level;
  logic [31:0] cal_nxt;
  logic cal_wrap;
  logic [7:0] addr;
  logic access;
  logic mapped;
  logic sync_reg;
  logic protect;
  logic enable;
  logic twelve;
  logic clr_match;
  rtcv_mode_t mode;
  logic tick;
  logic apply;
  logic [31:0] rd_mux;
  logic [31:0] value_view;

  // Tick pin brought into the bus clock domain
  rtcv_pin_sync u_tick_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(tick_clock),
    .level(tick_level)
  );

  // Calendar successor of the current value
  rtcv_cal_next u_cal (
    .cal(s_r.count),
    .twelve_hour_select(twelve),
    .cal_nxt(cal_nxt),
    .year_wrap(cal_wrap)
  );

  // Control fields and address decode
  assign addr = 8'(paddr);
  assign access = psel && penable;
  assign enable = s_r.ctrl[RTCV_CTRL_EN_BIT];
  assign twelve = s_r.ctrl[RTCV_CTRL_TWELVE_BIT];
  assign clr_match = s_r.ctrl[RTCV_CTRL_CLR_BIT];
  assign protect = s_r.ctrl[RTCV_CTRL_WPROT_BIT];
  assign mode = rtcv_mode_t'(s_r.ctrl[RTCV_CTRL_MODE_LSB +: 2]);
  assign sync_reg = (addr == RTCV_OFS_VALUE) || (addr == RTCV_OFS_TOP) ||
                    (addr == RTCV_OFS_MATCH);
  assign mapped = sync_reg || (addr == RTCV_OFS_CTRL) ||
                  (addr == RTCV_OFS_FLAGS) || (addr == RTCV_OFS_STATUS);

  // Counter16 mode exposes only the low half of the value
  assign value_view = (mode == RTCV_MODE_C16) ?
                      {16'h0000, s_r.count[15:0]} : s_r.count;

  // Read data selection, unmapped and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr)
      RTCV_OFS_CTRL: begin
        rd_mux = {{(32 - RTCV_CTRL_W){1'b0}}, s_r.ctrl};
      end
      RTCV_OFS_FLAGS: begin
        rd_mux[RTCV_FLAG_WRAP_BIT] = s_r.wrap;
        rd_mux[RTCV_FLAG_MATCH_BIT] = s_r.mflag;
      end
      RTCV_OFS_STATUS: begin
        rd_mux[RTCV_STAT_SYNC_BIT] = (s_r.st != RTCV_SYNC_IDLE);
      end
      RTCV_OFS_VALUE: begin
        rd_mux = value_view;
      end
      RTCV_OFS_TOP: begin
        rd_mux = {16'h0000, s_r.top};
      end
      RTCV_OFS_MATCH: begin
        rd_mux = s_r.match;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Bus handshake: value reads and synchronised writes may stall
  always_comb begin
    pready = 1'b0;
    pslverr = 1'b0;
    if (access) begin
      if (!mapped) begin
        pready = 1'b1;
        pslverr = 1'b1;
      end else if (!pwrite && addr == RTCV_OFS_VALUE) begin
        pready = (s_r.st == RTCV_SYNC_RD) &&
                 (s_r.cnt == RTCV_RD_SYNC_CYC - 2'h1);
      end else if (pwrite && sync_reg && protect) begin
        pready = 1'b1;
        pslverr = 1'b1;
      end else if (pwrite && sync_reg) begin
        pready = (s_r.st == RTCV_SYNC_IDLE);
      end else begin
        pready = 1'b1;
      end
    end
  end

  // Tick edge and point where a pending write reaches the counter
  assign tick = tick_level && !s_r.tprev;
  assign apply = (s_r.st == RTCV_SYNC_WR) && (tick || !enable);

  // Next-state logic of the whole block
  always_comb begin
    s_nxt = s_r;
    s_nxt.tprev = tick_level;
    if (psel) begin
      s_nxt.prdata = rd_mux;
    end

    // Software writes to plain registers
    if (access && pwrite && pready && !pslverr) begin
      if (addr == RTCV_OFS_CTRL) begin
        s_nxt.ctrl = pwdata[RTCV_CTRL_W-1:0];
      end
      if (addr == RTCV_OFS_FLAGS) begin
        if (pwdata[RTCV_FLAG_WRAP_BIT]) begin
          s_nxt.wrap = 1'b0;
        end
        if (pwdata[RTCV_FLAG_MATCH_BIT]) begin
          s_nxt.mflag = 1'b0;
        end
      end
    end

    // Synchronisation sequencer
    unique case (s_r.st)
      RTCV_SYNC_IDLE: begin
        if (access && pwrite && sync_reg && !protect) begin
          s_nxt.st = RTCV_SYNC_WR;
          s_nxt.wdata = pwdata;
          s_nxt.waddr = addr;
        end else if (access && !pwrite && addr == RTCV_OFS_VALUE) begin
          s_nxt.st = RTCV_SYNC_RD;
          s_nxt.cnt = 2'h0;
        end
      end
      RTCV_SYNC_WR: begin
        if (apply) begin
          s_nxt.st = RTCV_SYNC_IDLE;
        end
      end
      RTCV_SYNC_RD: begin
        if (s_r.cnt == RTCV_RD_SYNC_CYC - 2'h1) begin
          s_nxt.st = RTCV_SYNC_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + 2'h1;
        end
      end
      default: begin
        s_nxt.st = RTCV_SYNC_IDLE;
      end
    endcase

    // Counting on each tick; a pending value write replaces one count
    if (apply && s_r.waddr == RTCV_OFS_VALUE) begin
      s_nxt.count = (mode == RTCV_MODE_C16) ?
                    {16'h0000, s_r.wdata[15:0]} : s_r.wdata;
    end else if (tick && enable) begin
      unique case (mode)
        RTCV_MODE_C16: begin
          if (s_r.count[15:0] == s_r.top) begin
            s_nxt.count = 32'h0000_0000;
            s_nxt.wrap = 1'b1;
          end else begin
            s_nxt.count = {16'h0000, s_r.count[15:0] + 16'h0001};
          end
        end
        RTCV_MODE_CAL: begin
          s_nxt.count = cal_nxt;
          if (cal_wrap) begin
            s_nxt.wrap = 1'b1;
          end
        end
        default: begin
          if (s_r.count == s_r.match) begin
            s_nxt.mflag = 1'b1;
          end
          if (s_r.count == s_r.match && clr_match) begin
            s_nxt.count = 32'h0000_0000;
          end else begin
            s_nxt.count = s_r.count + 32'h0000_0001;
            if (s_r.count == 32'hffff_ffff) begin
              s_nxt.wrap = 1'b1;
            end
          end
        end
      endcase
    end

    // Pending top and match writes land in the counter domain
    if (apply && s_r.waddr == RTCV_OFS_TOP) begin
      s_nxt.top = s_r.wdata[15:0];
    end
    if (apply && s_r.waddr == RTCV_OFS_MATCH) begin
      s_nxt.match = s_r.wdata;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.ctrl <= RTCV_CTRL_RST;
      s_r.count <= RTCV_VALUE_RST;
      s_r.top <= RTCV_TOP_RST;
      s_r.match <= RTCV_MATCH_RST;
      s_r.wrap <= 1'b0;
      s_r.mflag <= 1'b0;
      s_r.st <= RTCV_SYNC_IDLE;
      s_r.cnt <= 2'h0;
      s_r.wdata <= 32'h0000_0000;
      s_r.waddr <= 8'h00;
      s_r.tprev <= 1'b0;
      s_r.prdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign prdata = s_r.prdata;
  assign sync_pending = (s_r.st != RTCV_SYNC_IDLE);
  assign match_flag = s_r.mflag;
  assign wrap_flag = s_r.wrap;

endmodule : rtcv_top

// File: verification/rtcv_top_monitor.sv
// Port assertions of the real time counter value block
module rtcv_monitor
  import rtcv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tick_clock,
  input wire logic sync_pending,
  input wire logic match_flag,
  input wire logic wrap_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_q;
  logic [3:0] quiet;
  logic acc;
  logic fl_wr;

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Cycles since the tick pin last moved, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
      quiet <= 4'hf;
    end else begin
      tick_q <= tick_clock;
      if (tick_clock != tick_q) begin
        quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
        quiet <= quiet + 4'h1;
      end
    end
  end

  // Completed transfer and flag register write
  assign acc = psel && penable && pready;
  assign fl_wr = acc && pwrite && paddr == RTCV_OFS_FLAGS;

  sequence s_rd_setup;
    psel && !penable && !pwrite && paddr == RTCV_OFS_VALUE && !sync_pending;
  endsequence
  sequence s_rd_wait;
    !pready ##1 (!pready && sync_pending) ##1 pready;
  endsequence

  property p_rd_sync;
    s_rd_setup |=> s_rd_wait;
  endproperty
  property p_rd_done;
    acc && !pwrite && paddr == RTCV_OFS_VALUE |=> !sync_pending;
  endproperty
  property p_wr_fast;
    psel && penable && pwrite && paddr == RTCV_OFS_MATCH && !sync_pending
      |-> pready;
  endproperty
  property p_wr_sync;
    acc && pwrite && !pslverr && paddr == RTCV_OFS_MATCH |=> sync_pending;
  endproperty
  property p_unmapped;
    acc && paddr == 8'h04 |-> pslverr;
  endproperty
  property p_set_tick;
    $rose(match_flag) |-> quiet < 4'h9;
  endproperty
  property p_wrap_tick;
    $rose(wrap_flag) |-> quiet < 4'h9;
  endproperty
  property p_match_hold;
    match_flag && !(fl_wr && pwdata[RTCV_FLAG_MATCH_BIT]) |=> match_flag;
  endproperty
  property p_match_clr;
    fl_wr && pwdata[RTCV_FLAG_MATCH_BIT] && quiet > 4'h9 |=> !match_flag;
  endproperty
  property p_wrap_clr;
    fl_wr && pwdata[RTCV_FLAG_WRAP_BIT] && quiet > 4'h9 |=> !wrap_flag;
  endproperty

  a_rd_sync: assert property (p_rd_sync)
    else $error("value read wait wrong");
  a_rd_done: assert property (p_rd_done)
    else $error("sync pending after read");
  a_wr_fast: assert property (p_wr_fast)
    else $error("idle match write stalled");
  a_wr_sync: assert property (p_wr_sync)
    else $error("match write sync not started");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_set_tick: assert property (p_set_tick)
    else $error("match flag without tick");
  a_wrap_tick: assert property (p_wrap_tick)
    else $error("wrap flag without tick");
  a_match_hold: assert property (p_match_hold)
    else $error("match flag lost");
  a_match_clr: assert property (p_match_clr)
    else $error("match flag not cleared");
  a_wrap_clr: assert property (p_wrap_clr)
    else $error("wrap flag not cleared");
endmodule : rtcv_monitor

// File: verification/tb_rtc_counter_calendar_values.sv
// Self-checking bench of the real time counter value block
module tb_rtc_counter_calendar_values
  import rtcv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r, t, q_x;
  logic pready, pslverr, sync_pending, match_flag, wrap_flag, err;
  logic [1:0] fl_p, fl_x;
  logic tick_clock = 1'b0;
  logic [31:0] seed = 32'h210c28fb;
  logic [31:0] exp_q[$];
  int errors = 0;
  int checks = 0;

`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); \
  end \
end

  rtcv_top #(.ADDR_W(8)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tick_clock,
    .sync_pending, .match_flag, .wrap_flag);

  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++n > 50) begin
        errors++;
        print_verdict();
      end
      @(posedge pclk);
    end
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // One counter tick, long enough for the pin filter
  task automatic tick();
    @(posedge pclk);
    tick_clock <= 1'b1;
    repeat (6) @(posedge pclk);
    tick_clock <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : tick

  // One second from hh:59:59 in calendar mode, then read back
  task automatic cal(input logic [31:0] c, input logic [5:0] y,
    input logic [3:0] m, input logic [4:0] d, input logic [4:0] h,
    input logic [5:0] y2, input logic [3:0] m2, input logic [4:0] d2,
    input logic [4:0] h2);
    wr(RTCV_OFS_CTRL, c);
    wr(RTCV_OFS_VALUE, {y, m, d, h, 6'h3b, 6'h3b});
    wr(RTCV_OFS_CTRL, c | 32'h1);
    tick();
    wr(RTCV_OFS_CTRL, c);
    rd(RTCV_OFS_VALUE, {y2, m2, d2, h2, 12'h000});
  endtask : cal

  // Compares each completed read with the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      q_x = exp_q.pop_front();
      `CHK(prdata, q_x)
      // Flag reads also check the flag pins against the same note
      if (paddr == RTCV_OFS_FLAGS) begin
        fl_p = {wrap_flag, match_flag};
        fl_x = {q_x[RTCV_FLAG_WRAP_BIT], q_x[RTCV_FLAG_MATCH_BIT]};
        `CHK(fl_p, fl_x)
      end
    end
  end

  initial begin
    forever #20 pclk = ~pclk;
  end

  // Watchdog well beyond the length of the whole sequence
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(RTCV_OFS_VALUE, 32'h0);
    rd(RTCV_OFS_TOP, 32'h0);
    rd(RTCV_OFS_MATCH, 32'h0);
    r = rnd() & 32'h7fff_ffff;
    wr(RTCV_OFS_VALUE, r);
    wr(RTCV_OFS_MATCH, r + 32'h2);
    rd(RTCV_OFS_VALUE, r);
    rd(RTCV_OFS_MATCH, r + 32'h2);
    wr(RTCV_OFS_CTRL, 32'h1);
    repeat (2) tick();
    rd(RTCV_OFS_FLAGS, 32'h0);
    tick();
    rd(RTCV_OFS_FLAGS, 32'h1);
    wr(RTCV_OFS_FLAGS, 32'h0);
    rd(RTCV_OFS_FLAGS, 32'h1);
    wr(RTCV_OFS_FLAGS, 32'h1);
    rd(RTCV_OFS_FLAGS, 32'h0);
    rd(RTCV_OFS_VALUE, r + 32'h3);
    wr(RTCV_OFS_CTRL, 32'h80);
    wr(RTCV_OFS_VALUE, r + 32'h1);
    wr(RTCV_OFS_CTRL, 32'h81);
    repeat (2) tick();
    rd(RTCV_OFS_FLAGS, 32'h1);
    rd(RTCV_OFS_VALUE, 32'h0);
    wr(RTCV_OFS_CTRL, 32'h0);
    wr(RTCV_OFS_VALUE, 32'hffff_ffff);
    wr(RTCV_OFS_CTRL, 32'h1);
    tick();
    rd(RTCV_OFS_FLAGS, 32'h81);
    rd(RTCV_OFS_VALUE, 32'h0);
    wr(RTCV_OFS_FLAGS, 32'h81);
    rd(RTCV_OFS_FLAGS, 32'h0);
    t = rnd() | 32'h1;
    wr(RTCV_OFS_CTRL, 32'h4);
    wr(RTCV_OFS_TOP, t);
    wr(RTCV_OFS_VALUE, t - 32'h1);
    rd(RTCV_OFS_TOP, {16'h0, t[15:0]});
    rd(RTCV_OFS_VALUE, {16'h0, t[15:0] - 16'h1});
    wr(RTCV_OFS_CTRL, 32'h5);
    tick();
    rd(RTCV_OFS_FLAGS, 32'h0);
    tick();
    rd(RTCV_OFS_FLAGS, 32'h80);
    rd(RTCV_OFS_VALUE, 32'h0);
    wr(RTCV_OFS_FLAGS, 32'h80);
    // Reserved mode counts as counter32; a match write waits for a tick
    wr(RTCV_OFS_CTRL, 32'hd);
    wr(RTCV_OFS_MATCH, r + 32'h2);
    rd(RTCV_OFS_STATUS, 32'h80);
    tick();
    rd(RTCV_OFS_STATUS, 32'h0);
    rd(RTCV_OFS_VALUE, 32'h1);
    wr(RTCV_OFS_CTRL, 32'h100);
    wr(RTCV_OFS_MATCH, 32'h5);
    `CHK(err, 1'b1)
    rd(RTCV_OFS_MATCH, r + 32'h2);
    rd(8'h04, 32'h0);
    `CHK(err, 1'b1)
    cal(32'h8, 6'h03, 4'h2, 5'h1c, 5'h17, 6'h03, 4'h3, 5'h01, 5'h00);
    cal(32'h8, 6'h04, 4'h2, 5'h1c, 5'h17, 6'h04, 4'h2, 5'h1d, 5'h00);
    cal(32'h8, 6'h05, 4'hc, 5'h1f, 5'h17, 6'h06, 4'h1, 5'h01, 5'h00);
    cal(32'h48, 6'h01, 4'h4, 5'h1e, 5'h1b, 6'h01, 4'h5, 5'h01, 5'h0c);
    cal(32'h48, 6'h01, 4'h6, 5'h0a, 5'h0b, 6'h01, 4'h6, 5'h0a, 5'h1c);
    cal(32'h48, 6'h01, 4'h6, 5'h0a, 5'h1c, 6'h01, 4'h6, 5'h0a, 5'h11);
    cal(32'h8, 6'h3f, 4'hc, 5'h1f, 5'h17, 6'h00, 4'h1, 5'h01, 5'h00);
    rd(RTCV_OFS_FLAGS, 32'h80);
    print_verdict();
  end
endmodule : tb_rtc_counter_calendar_values

bind rtcv_top rtcv_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .tick_clock, .sync_pending, .match_flag, .wrap_flag);
